// *** logic/dct_timer_top.sv ***
// Timer section: control, vector, preload, count and status registers,
// the register bus slave and the timer pins.
// Assumes all pins are synchronous to clk and the host holds a bus cycle
// until the transfer acknowledge is seen.
`timescale 1ns/100ps
`include "dct_defs.svh"

// How it works
// RQ1 - Vector reads same in read and acknowledge
// RQ2 - Reset loads vector with 0f
// RQ3 - Three addressable preload bytes form reload
// RQ4 - Null pad below preload high reads zero
// RQ5 - Preload access allowed anytime, unguarded
// RQ6 - Software never programs preload of zero
// RQ7 - Reset keeps preload and counter contents
// RQ8 - Live count readable, writes ignored
// RQ9 - Null pad below count high reads zero
// RQ10 - Flag sets on one to zero decrement
// RQ11 - Status reads harmless; write one clears
// RQ12 - Reset clears control: halt, port pins
// RQ13 - Halt keeps counter stable and readable
// RQ14 - Halt forces prescaler to 1f
// RQ15 - Halt forces zero flag low
// RQ16 - Run clocks counter from chosen source
// RQ17 - Counter clocked by prescaler or pin
// RQ18 - First prescaler rollover loads, then counts
// RQ19 - First input edge loads, then counts
// RQ20 - Counter clock at most clk over eight
// RQ21 - Run needs enable, and input when gated
// RQ22 - Zero control: reload or roll over
// RQ23 - Clock control field selects clock source
// RQ24 - Square wave toggles on zero, high halted
// RQ25 - Acknowledge answered only with request asserted
module dct_timer_top (
   input wire logic clk,
   input wire logic reset,
   input wire logic chip_select_n,
   input wire logic read_not_write,
   input wire logic [4:0] reg_select,
   input wire logic [7:0] data_in,
   output logic [7:0] data_out,
   output logic data_oe,
   output logic transfer_acknowledge_n,
   output logic transfer_acknowledge_oe,
   input wire logic timer_int_acknowledge_n,
   input wire logic timer_input_pin,
   output logic timer_output_pin_o,
   output logic timer_output_pin_oe,
   output logic dual_input_pin_timer,
   output logic dual_acknowledge_pin_timer,
   output logic timer_running
);

   dct_pkg::dct_top_state_t st_r;
   dct_pkg::dct_top_state_t st_nxt;
   dct_pkg::dct_bus_req_t req;

   logic [1:0] clk_ctl;
   logic [2:0] out_ctl;
   logic run;
   logic pin_rise;
   logic pre_tick;
   logic pre_roll;
   logic cnt_clk;
   logic zero_hit;
   logic [23:0] cnt_value;
   logic [23:0] preload;
   logic irq_vectored;
   logic take;
   logic iack_take;
   logic [7:0] rd_val;

   // ==========================================================
   // Run state and clock selection
   assign clk_ctl = st_r.timer_control_reg[`DCT_CTL_CLK_HI:`DCT_CTL_CLK_LO];
   assign out_ctl = st_r.timer_control_reg[`DCT_CTL_OUT_HI:`DCT_CTL_OUT_LO];
   assign run = st_r.timer_control_reg[`DCT_CTL_ENABLE] &
      ((clk_ctl != `DCT_CLK_GATED) | timer_input_pin); // RQ21
   assign pin_rise = timer_input_pin & ~st_r.pin_prev;
   // System clock prescaling ticks every cycle; input modes tick on edges
   assign pre_tick = clk_ctl[1] ? pin_rise : 1'b1; // RQ23
   assign cnt_clk = (clk_ctl == `DCT_CLK_PIN) ?
      (run & pin_rise) : pre_roll; // RQ17 RQ19
   assign preload = {st_r.preload_high, st_r.preload_mid, st_r.preload_low};

   dct_prescaler u_pre (
      .clk(clk),
      .reset(reset),
      .run(run & (clk_ctl != `DCT_CLK_PIN)),
      .tick(pre_tick),
      .count(),
      .rollover(pre_roll)
   );

   dct_down_counter u_cnt (
      .clk(clk),
      .reset(reset),
      .run(run),
      .clk_en(cnt_clk),
      .rollover_mode(st_r.timer_control_reg[`DCT_CTL_ZD_CTRL]),
      .preload(preload),
      .count(cnt_value),
      .zero_hit(zero_hit)
   );

   // ==========================================================
   // Bus cycle qualification
   assign req.sel = ~chip_select_n;
   assign req.rd = read_not_write;
   assign req.addr = reg_select;
   assign req.wdata = data_in;
   assign irq_vectored = (out_ctl == `DCT_OUT_VECTORED) &
      st_r.zero_detect_flag;
   assign take = req.sel & ~st_r.busy;
   assign iack_take = ~timer_int_acknowledge_n & ~req.sel & ~st_r.busy &
      irq_vectored; // RQ25

   // ==========================================================
   // Read data multiplexer; count bytes come live, unlatched
   always_comb begin
      rd_val = `DCT_BYTE_ZERO;
      case (req.addr)
         `DCT_OFS_CONTROL: begin
            rd_val = st_r.timer_control_reg;
            rd_val[`DCT_CTL_UNUSED] = 1'b0;
         end
         `DCT_OFS_VECTOR: rd_val = st_r.timer_vector; // RQ1
         `DCT_OFS_PRE_NULL: rd_val = `DCT_BYTE_ZERO; // RQ4
         `DCT_OFS_PRE_HIGH: rd_val = st_r.preload_high; // RQ3
         `DCT_OFS_PRE_MID: rd_val = st_r.preload_mid; // RQ3
         `DCT_OFS_PRE_LOW: rd_val = st_r.preload_low; // RQ3
         `DCT_OFS_CNT_NULL: rd_val = `DCT_BYTE_ZERO; // RQ9
         `DCT_OFS_CNT_HIGH: rd_val = cnt_value[23:16]; // RQ8
         `DCT_OFS_CNT_MID: rd_val = cnt_value[15:8]; // RQ8
         `DCT_OFS_CNT_LOW: rd_val = cnt_value[7:0]; // RQ8
         `DCT_OFS_STATUS: rd_val[`DCT_ZFLAG_BIT] = st_r.zero_detect_flag;
         default: rd_val = `DCT_BYTE_ZERO;
      endcase
   end

   // ==========================================================
   // Next state
   always_comb begin
      st_nxt = st_r;
      st_nxt.pin_prev = timer_input_pin;
      // Cycle ends once both strobes are negated
      if (st_r.busy & ~req.sel & timer_int_acknowledge_n) begin
         st_nxt.busy = 1'b0;
         st_nxt.is_read = 1'b0;
      end
      if (take) begin
         st_nxt.busy = 1'b1;
         st_nxt.is_read = req.rd;
         st_nxt.rdata = req.rd ? rd_val : `DCT_BYTE_ZERO;
         if (!req.rd) begin
            // Null pads, count bytes and unmapped writes are dropped
            case (req.addr)
               `DCT_OFS_CONTROL: st_nxt.timer_control_reg = req.wdata;
               `DCT_OFS_VECTOR: st_nxt.timer_vector = req.wdata;
               `DCT_OFS_PRE_HIGH: st_nxt.preload_high = req.wdata; // RQ5
               `DCT_OFS_PRE_MID: st_nxt.preload_mid = req.wdata; // RQ5
               `DCT_OFS_PRE_LOW: st_nxt.preload_low = req.wdata; // RQ5
               `DCT_OFS_STATUS: begin
                  if (req.wdata[`DCT_ZFLAG_BIT]) begin
                     st_nxt.zero_detect_flag = 1'b0; // RQ11
                  end
               end
               default: st_nxt.rdata = st_nxt.rdata;
            endcase
         end
      end
      if (iack_take) begin
         st_nxt.busy = 1'b1;
         st_nxt.is_read = 1'b1;
         st_nxt.rdata = st_r.timer_vector; // RQ1 RQ25
      end
      // A zero detect in the clearing cycle wins over the clear
      if (zero_hit) begin
         st_nxt.zero_detect_flag = 1'b1; // RQ10
      end
      if (!run) begin
         st_nxt.zero_detect_flag = 1'b0; // RQ15
         st_nxt.wave_level = 1'b1; // RQ24
      end else if (zero_hit) begin
         st_nxt.wave_level = ~st_r.wave_level; // RQ24
      end
      // Preload bytes are left alone so reset keeps them
      if (reset) begin
         st_nxt.timer_control_reg = `DCT_CTL_RESET; // RQ12
         st_nxt.timer_vector = `DCT_VECTOR_RESET; // RQ2
         st_nxt.zero_detect_flag = 1'b0;
         st_nxt.wave_level = 1'b1;
         st_nxt.pin_prev = 1'b0;
         st_nxt.busy = 1'b0;
         st_nxt.is_read = 1'b0;
         st_nxt.rdata = `DCT_BYTE_ZERO;
      end
   end

   always_ff @(posedge clk) begin
      st_r <= st_nxt;
   end

   // ==========================================================
   // Outputs
   assign data_out = st_r.rdata;
   assign data_oe = st_r.busy & st_r.is_read;
   assign transfer_acknowledge_n = ~st_r.busy;
   assign transfer_acknowledge_oe = st_r.busy;
   assign timer_running = run; // RQ16

   // Port C use shows as pin released; interrupt request drives low on flag
   always_comb begin
      timer_output_pin_o = 1'b1;
      timer_output_pin_oe = 1'b0;
      if (out_ctl[2:1] == `DCT_OUT_SQUARE) begin
         timer_output_pin_o = st_r.wave_level; // RQ24
         timer_output_pin_oe = 1'b1;
      end else if (out_ctl == `DCT_OUT_VECTORED ||
                   out_ctl == `DCT_OUT_AUTOVEC) begin
         timer_output_pin_o = ~st_r.zero_detect_flag;
         timer_output_pin_oe = 1'b1;
      end
   end

   assign dual_input_pin_timer = (clk_ctl != `DCT_CLK_SYS); // RQ23
   assign dual_acknowledge_pin_timer = (out_ctl[2:1] == 2'h2); // RQ12

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   chk_vector_reset: assert property (
      $fell(reset) |-> st_r.timer_vector == 8'h0f) // RQ2
      else $error("vector not 0f after reset");
   chk_control_reset: assert property (
      $fell(reset) |-> st_r.timer_control_reg == 8'h00 &&
      !timer_output_pin_oe) // RQ12
      else $error("control not cleared by reset");
   chk_iack_vector: assert property (
      iack_take |=> !transfer_acknowledge_n && data_oe &&
      data_out == $past(st_r.timer_vector)) // RQ1 RQ25
      else $error("acknowledge did not return the vector");
   chk_iack_refused: assert property (
      !timer_int_acknowledge_n && !req.sel && !st_r.busy &&
      !irq_vectored |=> transfer_acknowledge_n && !data_oe) // RQ25
      else $error("acknowledge answered without request");
   chk_null_reads: assert property (
      take && req.rd && (req.addr == 5'h12 || req.addr == 5'h16)
      |=> data_out == 8'h00) // RQ4 RQ9
      else $error("null pad read not zero");
   chk_preload_write: assert property (
      take && !req.rd && req.addr == 5'h14
      |=> st_r.preload_mid == $past(req.wdata)) // RQ3 RQ5
      else $error("preload byte not written");
   chk_count_ro: assert property (
      take && !req.rd && req.addr == 5'h18 && !run
      |=> cnt_value == $past(cnt_value)) // RQ8
      else $error("count write changed the counter");
   chk_zds_sets: assert property (
      zero_hit |=> st_r.zero_detect_flag) // RQ10
      else $error("zero detect flag not set");
   chk_zds_halt: assert property (
      !run |=> !st_r.zero_detect_flag) // RQ15
      else $error("zero detect flag set in halt");
   chk_zds_clear: assert property (
      take && !req.rd && req.addr == 5'h1a && req.wdata[0] && !zero_hit
      |=> !st_r.zero_detect_flag) // RQ11
      else $error("status write did not clear flag");
   chk_status_read: assert property (
      take && req.rd && req.addr == 5'h1a && run && !zero_hit
      |=> st_r.zero_detect_flag == $past(st_r.zero_detect_flag)) // RQ11
      else $error("status read changed flag");
   chk_square_toggle: assert property (
      run && zero_hit && out_ctl[2:1] == 2'h1
      |=> timer_output_pin_o != $past(timer_output_pin_o)) // RQ24
      else $error("square wave did not toggle");
   chk_square_halt: assert property (
      !run && out_ctl[2:1] == 2'h1 |=> timer_output_pin_o) // RQ24
      else $error("square wave not high in halt");
   chk_gated_halt: assert property (
      clk_ctl == 2'h1 && !timer_input_pin |=> !zero_hit [*2]) // RQ21
      else $error("gated timer counted with input low");

   cov_zero_hit: cover property (run ##1 zero_hit);
   cov_iack: cover property (iack_take ##1 !transfer_acknowledge_n);
   cov_square: cover property (
      out_ctl[2:1] == 2'h1 && zero_hit ##1 !timer_output_pin_o);

endmodule : dct_timer_top

// *** pkg/dct_defs.svh ***
// Register offsets, control field positions, reset values and counts
// for the down counter timer core.
// Assumes it is included by bare name from the top, prescaler and counter files.
`ifndef DCT_DEFS_SVH
`define DCT_DEFS_SVH

// ==========================================================
// Register offsets on the 5-bit register select
`define DCT_OFS_CONTROL 5'h10
`define DCT_OFS_VECTOR 5'h11
`define DCT_OFS_PRE_NULL 5'h12
`define DCT_OFS_PRE_HIGH 5'h13
`define DCT_OFS_PRE_MID 5'h14
`define DCT_OFS_PRE_LOW 5'h15
`define DCT_OFS_CNT_NULL 5'h16
`define DCT_OFS_CNT_HIGH 5'h17
`define DCT_OFS_CNT_MID 5'h18
`define DCT_OFS_CNT_LOW 5'h19
`define DCT_OFS_STATUS 5'h1a

// ==========================================================
// Control register fields
`define DCT_CTL_ENABLE 0
`define DCT_CTL_CLK_LO 1
`define DCT_CTL_CLK_HI 2
`define DCT_CTL_UNUSED 3
`define DCT_CTL_ZD_CTRL 4
`define DCT_CTL_OUT_LO 5
`define DCT_CTL_OUT_HI 7
`define DCT_ZFLAG_BIT 0

// Clock control encodings
`define DCT_CLK_SYS 2'h0
`define DCT_CLK_GATED 2'h1
`define DCT_CLK_PIN_PRE 2'h2
`define DCT_CLK_PIN 2'h3

// Output pin encodings (bits 7..6, and 7..5)
`define DCT_OUT_SQUARE 2'h1
`define DCT_OUT_VECTORED 3'h5
`define DCT_OUT_AUTOVEC 3'h7

// ==========================================================
// Reset values and counts
`define DCT_CTL_RESET 8'h00
`define DCT_VECTOR_RESET 8'h0f
`define DCT_PRE_TOP 5'h1f
`define DCT_PRE_BOTTOM 5'h00
`define DCT_CNT_ONE 24'h000001
`define DCT_CNT_ZERO 24'h000000
`define DCT_BYTE_ZERO 8'h00

`endif

// *** pkg/dct_pkg.sv ***
// Types shared by the down counter timer core modules.
// Assumes dct_defs.svh holds the numeric constants.
package dct_pkg;

   // ==========================================================
   // Register bus request as seen in one clock cycle
   typedef struct packed {
      logic sel;
      logic rd;
      logic [4:0] addr;
      logic [7:0] wdata;
   } dct_bus_req_t;

   // ==========================================================
   // State of the top module
   typedef struct packed {
      logic [7:0] timer_control_reg;
      logic [7:0] timer_vector;
      logic [7:0] preload_high;
      logic [7:0] preload_mid;
      logic [7:0] preload_low;
      logic zero_detect_flag;
      logic wave_level;
      logic pin_prev;
      logic busy;
      logic is_read;
      logic [7:0] rdata;
   } dct_top_state_t;

   // State of the prescaler
   typedef struct packed {
      logic [4:0] count;
   } dct_pre_state_t;

   // State of the 24-bit counter
   typedef struct packed {
      logic [23:0] count;
      logic loaded;
   } dct_cnt_state_t;

endpackage : dct_pkg

// *** logic/dct_prescaler.sv ***
// Five-bit divide-by-32 prescaler of the timer.
// Assumes tick is a one-cycle enable and run comes from the control state.
`timescale 1ns/100ps
`include "dct_defs.svh"

module dct_prescaler (
   input wire logic clk,
   input wire logic reset,
   input wire logic run,
   input wire logic tick,
   output logic [4:0] count,
   output logic rollover
);

   dct_pkg::dct_pre_state_t st_r;
   dct_pkg::dct_pre_state_t st_nxt;

   // ==========================================================
   // Next state
   always_comb begin
      st_nxt = st_r;
      if (!run) begin
         st_nxt.count = `DCT_PRE_TOP; // RQ14
      end else if (tick) begin
         st_nxt.count = st_r.count - 5'h01; // RQ16
      end
      if (reset) begin
         st_nxt.count = `DCT_PRE_TOP;
      end
   end

   always_ff @(posedge clk) begin
      st_r <= st_nxt;
   end

   assign count = st_r.count;
   // Passing 00 to 1F is the counter clock
   assign rollover = run & tick & (st_r.count == `DCT_PRE_BOTTOM); // RQ17

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   chk_pre_halt_top: assert property (!run |=> count == 5'h1f) // RQ14
      else $error("prescaler not held at 1f in halt");
   chk_pre_wraps: assert property (
      run && tick && count == 5'h00 |=> count == 5'h1f) // RQ18
      else $error("prescaler did not wrap to 1f");

endmodule : dct_prescaler

// *** logic/dct_down_counter.sv ***
// 24-bit synchronous down counter with preload, reload and rollover.
// Assumes clk_en is a one-cycle counter clock from the prescaler or pin.
// The count has no reset: it keeps its value across reset.
`timescale 1ns/100ps
`include "dct_defs.svh"

module dct_down_counter (
   input wire logic clk,
   input wire logic reset,
   input wire logic run,
   input wire logic clk_en,
   input wire logic rollover_mode,
   input wire logic [23:0] preload,
   output logic [23:0] count,
   output logic zero_hit
);

   dct_pkg::dct_cnt_state_t st_r;
   dct_pkg::dct_cnt_state_t st_nxt;
   logic reload;

   // First clock after run, or first clock after zero in reload mode
   assign reload = !st_r.loaded ||
      (st_r.count == `DCT_CNT_ZERO && !rollover_mode); // RQ22

   // ==========================================================
   // Next state
   always_comb begin
      st_nxt = st_r;
      if (!run) begin
         st_nxt.loaded = 1'b0; // RQ13
      end else if (clk_en) begin
         st_nxt.loaded = 1'b1;
         if (reload) begin
            st_nxt.count = preload; // RQ18 RQ19
         end else begin
            // Wraps to ffffff from zero in rollover mode
            st_nxt.count = st_r.count - `DCT_CNT_ONE; // RQ17
         end
      end
      if (reset) begin
         st_nxt.loaded = 1'b0; // RQ7
      end
   end

   always_ff @(posedge clk) begin
      st_r <= st_nxt;
   end

   assign count = st_r.count;
   assign zero_hit = run & clk_en & st_r.loaded &
      (st_r.count == `DCT_CNT_ONE); // RQ10

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   chk_first_load: assert property (
      run && clk_en && !st_r.loaded |=> count == $past(preload)) // RQ18
      else $error("first counter clock did not load preload");
   chk_halt_holds: assert property (
      !run |=> count === $past(count)) // RQ13
      else $error("counter changed in halt");
   chk_zero_reload: assert property (
      run && clk_en && st_r.loaded && count == 24'h000000 &&
      !rollover_mode |=> count == $past(preload)) // RQ22
      else $error("counter did not reload after zero");
   chk_zero_rolls: assert property (
      run && clk_en && st_r.loaded && count == 24'h000000 &&
      rollover_mode |=> count == 24'hffffff) // RQ22
      else $error("counter did not roll over after zero");

endmodule : dct_down_counter

// *** tb/dct_host_model.sv ***
// Host processor model that runs cycles on the timer register bus.
// Assumes the bench calls cycle and that clk is the system clock.
`timescale 1ns/100ps

module dct_host_model (
   input wire logic clk,
   output logic chip_select_n,
   output logic read_not_write,
   output logic [4:0] reg_select,
   output logic [7:0] data_in,
   output logic timer_int_acknowledge_n,
   input wire logic transfer_acknowledge_n,
   input wire logic [7:0] data_out,
   input wire logic data_oe
);
   // Extra cycles the host keeps its strobe after the acknowledge
   int hold = 0;

   initial begin
      chip_select_n = 1'b1;
      timer_int_acknowledge_n = 1'b1;
      read_not_write = 1'b1;
      reg_select = 5'h00;
      data_in = 8'h00;
   end

   // ==========================================================
   // One register or interrupt acknowledge cycle
   task automatic cycle(input logic rd, input logic ia,
      input logic [4:0] a, input logic [7:0] wd,
      output logic [7:0] rdata, output logic ok);
      int n;
      n = 0;
      @(posedge clk);
      chip_select_n <= ia;
      timer_int_acknowledge_n <= !ia;
      read_not_write <= rd;
      reg_select <= a;
      data_in <= wd;
      do begin
         @(posedge clk);
         n++;
      end while (transfer_acknowledge_n !== 1'b0 && n < 12);
      ok = (transfer_acknowledge_n === 1'b0);
      rdata = (data_oe === 1'b1) ? data_out : 8'hxx;
      repeat (hold) @(posedge clk);
      chip_select_n <= 1'b1;
      timer_int_acknowledge_n <= 1'b1;
      // A released bus shows inverted address and data, never a stale copy
      data_in <= ~wd;
      reg_select <= ~a;
      repeat (3) @(posedge clk);
   endtask : cycle
endmodule : dct_host_model

// *** tb/dct_timer_top_bench.sv ***
// Self-checking bench for the down counter timer core.
// Assumes the host model runs bus cycles; the bench drives the input pin.
`timescale 1ns/100ps
`include "dct_defs.svh"

module dct_timer_top_bench;
   logic clk, reset, timer_input_pin;
   logic chip_select_n, read_not_write, timer_int_acknowledge_n;
   logic [4:0] reg_select;
   logic [7:0] data_in, data_out;
   logic data_oe, transfer_acknowledge_n, transfer_acknowledge_oe;
   logic timer_output_pin_o, timer_output_pin_oe, timer_running;
   logic dual_input_pin_timer, dual_acknowledge_pin_timer;
   int failures = 0;
   int tests_run = 0;
   int cycles = 0;
   int n;

   dct_timer_top dct_timer_top_i (.clk(clk), .reset(reset),
      .chip_select_n(chip_select_n), .read_not_write(read_not_write),
      .reg_select(reg_select), .data_in(data_in), .data_out(data_out),
      .data_oe(data_oe), .transfer_acknowledge_n(transfer_acknowledge_n),
      .transfer_acknowledge_oe(transfer_acknowledge_oe),
      .timer_int_acknowledge_n(timer_int_acknowledge_n),
      .timer_input_pin(timer_input_pin),
      .timer_output_pin_o(timer_output_pin_o),
      .timer_output_pin_oe(timer_output_pin_oe),
      .dual_input_pin_timer(dual_input_pin_timer),
      .dual_acknowledge_pin_timer(dual_acknowledge_pin_timer),
      .timer_running(timer_running));

   dct_host_model dct_host_model_i (.clk(clk),
      .chip_select_n(chip_select_n), .read_not_write(read_not_write),
      .reg_select(reg_select), .data_in(data_in),
      .timer_int_acknowledge_n(timer_int_acknowledge_n),
      .transfer_acknowledge_n(transfer_acknowledge_n),
      .data_out(data_out), .data_oe(data_oe));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ==========================================================
   // Verdict, comparison and bus helpers
   task automatic results;
      if (failures == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : results

   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         $display("Error at %0t: run hung", $time);
         results();
      end
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic flag_chk(input logic seen, input logic exp);
      check({7'h00, seen}, {7'h00, exp});
   endtask : flag_chk

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      logic [7:0] r;
      logic ok;
      dct_host_model_i.cycle(1'b0, 1'b0, a, d, r, ok);
      flag_chk(ok, 1'b1);
   endtask : wr

   task automatic rd(input logic [4:0] a, input logic [7:0] exp);
      logic [7:0] r;
      logic ok;
      dct_host_model_i.cycle(1'b1, 1'b0, a, 8'h00, r, ok);
      flag_chk(ok, 1'b1);
      check(r, exp);
   endtask : rd

   task automatic iack(input logic exp_ok, input logic [7:0] exp);
      logic [7:0] r;
      logic ok;
      dct_host_model_i.cycle(1'b1, 1'b1, 5'h00, 8'h00, r, ok);
      flag_chk(ok, exp_ok);
      if (exp_ok) check(r, exp);
   endtask : iack

   // Nine-cycle period keeps the counter clock below clk over eight
   task automatic pulse;
      @(posedge clk);
      timer_input_pin <= 1'b1;
      repeat (4) @(posedge clk);
      timer_input_pin <= 1'b0;
      repeat (4) @(posedge clk);
   endtask : pulse

   // ==========================================================
   // Main sequence
   initial begin
      reset = 1'b1;
      timer_input_pin = 1'b0;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      rd(`DCT_OFS_CONTROL, 8'h00);
      rd(`DCT_OFS_VECTOR, 8'h0f);
      flag_chk(dual_input_pin_timer, 1'b0);
      wr(`DCT_OFS_VECTOR, 8'h5a);
      dct_host_model_i.hold = 2;
      rd(`DCT_OFS_VECTOR, 8'h5a);
      dct_host_model_i.hold = 0;
      wr(`DCT_OFS_PRE_HIGH, 8'h00);
      wr(`DCT_OFS_PRE_MID, 8'h00);
      wr(`DCT_OFS_PRE_LOW, 8'h03);
      wr(`DCT_OFS_PRE_NULL, 8'hff);
      rd(`DCT_OFS_PRE_NULL, 8'h00);
      wr(`DCT_OFS_CNT_NULL, 8'hff);
      rd(`DCT_OFS_CNT_NULL, 8'h00);
      rd(`DCT_OFS_PRE_LOW, 8'h03);
      rd(`DCT_OFS_PRE_HIGH, 8'h00);
      // Direct input clock, vectored interrupt, reload at zero
      wr(`DCT_OFS_CONTROL, 8'ha7);
      flag_chk(timer_running, 1'b1);
      flag_chk(dual_input_pin_timer, 1'b1);
      flag_chk(dual_acknowledge_pin_timer, 1'b1);
      iack(1'b0, 8'h00);
      flag_chk(transfer_acknowledge_oe, 1'b0);
      pulse();
      rd(`DCT_OFS_CNT_LOW, 8'h03);
      wr(`DCT_OFS_CNT_LOW, 8'h77);
      rd(`DCT_OFS_CNT_LOW, 8'h03);
      repeat (2) pulse();
      rd(`DCT_OFS_CNT_LOW, 8'h01);
      rd(`DCT_OFS_STATUS, 8'h00);
      pulse();
      rd(`DCT_OFS_STATUS, 8'h01);
      rd(`DCT_OFS_STATUS, 8'h01);
      rd(`DCT_OFS_CNT_LOW, 8'h00);
      flag_chk(timer_output_pin_oe, 1'b1);
      flag_chk(timer_output_pin_o, 1'b0);
      iack(1'b1, 8'h5a);
      wr(`DCT_OFS_STATUS, 8'hfe);
      rd(`DCT_OFS_STATUS, 8'h01);
      wr(`DCT_OFS_STATUS, 8'h01);
      rd(`DCT_OFS_STATUS, 8'h00);
      flag_chk(timer_output_pin_o, 1'b1);
      wr(`DCT_OFS_PRE_LOW, 8'h04);
      pulse();
      rd(`DCT_OFS_CNT_LOW, 8'h04);
      repeat (4) pulse();
      wr(`DCT_OFS_CONTROL, 8'ha6);
      rd(`DCT_OFS_STATUS, 8'h00);
      pulse();
      wr(`DCT_OFS_CNT_MID, 8'h55);
      rd(`DCT_OFS_CNT_MID, 8'h00);
      rd(`DCT_OFS_CNT_LOW, 8'h00);
      // Square wave with rollover at zero
      wr(`DCT_OFS_CONTROL, 8'h56);
      flag_chk(timer_output_pin_oe, 1'b1);
      flag_chk(timer_output_pin_o, 1'b1);
      wr(`DCT_OFS_CONTROL, 8'h57);
      repeat (5) pulse();
      flag_chk(timer_output_pin_o, 1'b0);
      pulse();
      rd(`DCT_OFS_CNT_HIGH, 8'hff);
      rd(`DCT_OFS_CNT_MID, 8'hff);
      rd(`DCT_OFS_CNT_LOW, 8'hff);
      // Gated system clock
      wr(`DCT_OFS_CONTROL, 8'h03);
      flag_chk(timer_running, 1'b0);
      timer_input_pin <= 1'b1;
      @(posedge clk);
      flag_chk(timer_running, 1'b1);
      timer_input_pin <= 1'b0;
      wr(`DCT_OFS_CONTROL, 8'h00);
      // System clock through the prescaler: load, then two counts
      wr(`DCT_OFS_PRE_LOW, 8'h02);
      wr(`DCT_OFS_CONTROL, 8'ha1);
      n = 0;
      while (timer_output_pin_o !== 1'b0 && n < 200) begin
         @(posedge clk);
         n++;
      end
      flag_chk(n >= 90 && n <= 97, 1'b1);
      wr(`DCT_OFS_CONTROL, 8'h00);
      // Input pin through the prescaler
      wr(`DCT_OFS_PRE_LOW, 8'h01);
      wr(`DCT_OFS_CONTROL, 8'h05);
      repeat (32) pulse();
      rd(`DCT_OFS_CNT_LOW, 8'h01);
      repeat (32) pulse();
      rd(`DCT_OFS_STATUS, 8'h01);
      // Reset keeps preload and count
      @(posedge clk);
      reset <= 1'b1;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      rd(`DCT_OFS_CONTROL, 8'h00);
      rd(`DCT_OFS_VECTOR, 8'h0f);
      rd(`DCT_OFS_PRE_LOW, 8'h01);
      rd(`DCT_OFS_CNT_LOW, 8'h00);
      rd(`DCT_OFS_STATUS, 8'h00);
      results();
   end
endmodule : dct_timer_top_bench
